// ---- src/ppoc_defs.vh ----
// Summary of operation
// (RULE1) an active override enable replaces the register-derived pin control
// (RULE2) oscillator input pin serves every clock source except calibrated oscillator
// (RULE3) with calibrated oscillator selected, port C bit 5 is plain I/O
// (RULE4) port C bit 5 is pin-change source 17, input on with group enable
// (RULE5) external clock: pull-up, direction, value overrides on bit 5, all zero
// (RULE6) crystal: pull-up, direction, value, input overrides on bits 5 and 4
// (RULE7) bit 4 input value is crystal AND source 16 AND group 2 enable
// (RULE8) reset-disable is fuse inverted; it or debug overrides bit 3, pull-up 1
// (RULE9) debug active only with fuse programmed and all lock bits unprogrammed
// (RULE10) bit 3 output forced 0; direction is debug AND transmit
// (RULE11) bit 3 input value is debug OR reset-disable AND source 15 AND group
// (RULE12) clock output: bit 2 overrides on, direction 1, value system clock
// (RULE13) system clock drives bit 2 during reset too
// (RULE14) bit 2 input on with interrupt 0, or source 14 with group 2
// (RULE15) two-wire mode: bit 1 direction is (hold OR data) AND direction bit
// (RULE16) control register bits 7 to 3 read zero
// (RULE17) control bit 2 enables break-before-make for port C
// (RULE18) control bit 1 enables break-before-make for port B
// (RULE19) control bit 0 enables break-before-make for port A
// (RULE20) break-before-make inserts one tri-state cycle when a pin becomes output
// (RULE21) port A pull-up register: eight read-write bits, reset 0
// (RULE22) port A data register: eight read-write bits, reset 0
`ifndef PPOC_DEFS_VH
`define PPOC_DEFS_VH
`define PPOC_ADDR_W        6
`define PPOC_OFS_PORT_A_OUTPUT_DATA_DAT 6'h11
`define PPOC_OFS_PORT_A_OUTPUT_DATA_PUE 6'h12
`define PPOC_OFS_SWCTL     6'h13
`define PPOC_OFS_DIR_A     6'h14
`define PPOC_OFS_DIR_B     6'h15
`define PPOC_OFS_DIR_C     6'h16
`define PPOC_OFS_PORTC_DAT 6'h17
`define PPOC_OFS_PORTC_PUE 6'h18
`define PPOC_OFS_STATUS    6'h19
`define PPOC_RST_BYTE      8'h00
`define PPOC_BBM_A_BIT     0
`define PPOC_BBM_B_BIT     1
`define PPOC_BBM_C_BIT     2
`define PPOC_SWCTL_MASK    8'h07
`define PPOC_BBM_CYCLES    1
`endif

// ---- src/ppoc_bbm.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ppoc_defs.vh"
module ppoc_bbm #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             rst_n,
  // control
  input  wire             bbm_en,
  input  wire [WIDTH-1:0] dir_req,
  // effective direction
  output wire [WIDTH-1:0] dir_out
);
  reg [WIDTH-1:0] prev_ff;
  // previous direction, to spot input-to-output turns
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= {WIDTH{1'b0}};
    end else begin
      prev_ff <= dir_req;
    end
  end
  // (RULE20) hold tri-state one cycle
  // a fresh output bit waits a cycle so the opposite driver lets go first
  assign dir_out = bbm_en ? (dir_req & prev_ff) : dir_req;
endmodule
`default_nettype wire

// ---- src/ppoc_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ppoc_defs.vh"
module ppoc_top #(
  parameter LOCK_W = 2
) (
  // clock and reset
  input  wire                    ref_clk,
  input  wire                    rst_n,
  // register port
  input  wire [`PPOC_ADDR_W-1:0] reg_addr,
  input  wire [7:0]              reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [7:0]              reg_rdata,
  // clock selection and fuses
  input  wire                    external_clock_selected,
  input  wire                    crystal_selected,
  input  wire                    reset_fuse,
  input  wire                    debug_fuse,
  input  wire [LOCK_W-1:0]       lock_bits,
  input  wire                    clock_out_fuse,
  input  wire                    power_down,
  // peripheral sources
  input  wire                    debug_transmit,
  input  wire                    external_interrupt_zero,
  input  wire [17:14]            pin_change_src,
  input  wire                    pin_change_group2_enable,
  input  wire                    two_wire_mode,
  input  wire                    serial_clock_hold,
  // port B direction from outside
  input  wire [3:0]              port_b_dir_req,
  // port A pins
  output wire [7:0]              port_a_out,
  output wire [7:0]              port_a_oe,
  output wire [7:0]              port_a_pullup,
  // port B effective direction
  output wire [3:0]              port_b_oe,
  // port C pins
  output wire [5:0]              port_c_out,
  output wire [5:0]              port_c_oe,
  output wire [5:0]              port_c_pullup,
  output wire [5:0]              port_c_in_en,
  // derived status
  output wire                    reset_pin_disable,
  output wire                    single_wire_debug_on,
  output wire                    clock_output_active
);
  reg  [7:0] port_a_output_data_ff;
  reg  [7:0] port_a_pullup_enable_ff;
  reg  [2:0] port_switching_control_ff;
  reg  [7:0] dir_a_ff;
  reg  [3:0] dir_b_ff;
  reg  [5:0] dir_c_ff;
  reg  [5:0] port_c_data_ff;
  reg  [5:0] port_c_pue_ff;
  reg  [7:0] nxt_rdata;
  wire [7:0] dir_a_eff;
  wire [5:0] dir_c_eff;
  wire       port_c_bbm_enable;
  wire       port_b_bbm_enable;
  wire       port_a_bbm_enable;
  // override vectors, bit n is port C pin n
  reg  [5:0] pullup_override_enable;
  reg  [5:0] pullup_override_value;
  reg  [5:0] direction_override_enable;
  reg  [5:0] direction_override_value;
  reg  [5:0] output_value_override_enable;
  reg  [5:0] output_value_override_value;
  reg  [5:0] input_enable_override_enable;
  reg  [5:0] input_enable_override_value;
  wire       src14_on;
  wire       src15_on;
  wire       src16_on;
  wire       src17_on;
  wire       clock_pin_busy;

  // one pin's value: override wins when enabled
  function ovr;
    input en;
    input val;
    input base;
    begin
      ovr = en ? val : base;
    end
  endfunction

  // (RULE17) port C switching bit
  assign port_c_bbm_enable = port_switching_control_ff[`PPOC_BBM_C_BIT];
  // (RULE18) port B switching bit
  assign port_b_bbm_enable = port_switching_control_ff[`PPOC_BBM_B_BIT];
  // (RULE19) port A switching bit
  assign port_a_bbm_enable = port_switching_control_ff[`PPOC_BBM_A_BIT];

  // register writes
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_output_data_ff     <= `PPOC_RST_BYTE;
      port_a_pullup_enable_ff   <= `PPOC_RST_BYTE;
      port_switching_control_ff <= 3'h0;
      dir_a_ff                  <= `PPOC_RST_BYTE;
      dir_b_ff                  <= 4'h0;
      dir_c_ff                  <= 6'h00;
      port_c_data_ff            <= 6'h00;
      port_c_pue_ff             <= 6'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        // (RULE22) port A data
        `PPOC_OFS_PORT_A_OUTPUT_DATA_DAT: port_a_output_data_ff <= reg_wdata;
        // (RULE21) port A pull-ups
        `PPOC_OFS_PORT_A_OUTPUT_DATA_PUE: port_a_pullup_enable_ff <= reg_wdata;
        `PPOC_OFS_SWCTL:     port_switching_control_ff <= reg_wdata[2:0];
        `PPOC_OFS_DIR_A:     dir_a_ff <= reg_wdata;
        `PPOC_OFS_DIR_B:     dir_b_ff <= reg_wdata[3:0];
        `PPOC_OFS_DIR_C:     dir_c_ff <= reg_wdata[5:0];
        `PPOC_OFS_PORTC_DAT: port_c_data_ff <= reg_wdata[5:0];
        `PPOC_OFS_PORTC_PUE: port_c_pue_ff <= reg_wdata[5:0];
        default: ;
      endcase
    end
  end

  // read mux, unmapped reads zero
  always @* begin
    case (reg_addr)
      `PPOC_OFS_PORT_A_OUTPUT_DATA_DAT: nxt_rdata = port_a_output_data_ff;
      `PPOC_OFS_PORT_A_OUTPUT_DATA_PUE: nxt_rdata = port_a_pullup_enable_ff;
      // (RULE16) upper control bits zero
      `PPOC_OFS_SWCTL:     nxt_rdata = {5'h00, port_switching_control_ff} & `PPOC_SWCTL_MASK;
      `PPOC_OFS_DIR_A:     nxt_rdata = dir_a_ff;
      `PPOC_OFS_DIR_B:     nxt_rdata = {4'h0, dir_b_ff};
      `PPOC_OFS_DIR_C:     nxt_rdata = {2'h0, dir_c_ff};
      `PPOC_OFS_PORTC_DAT: nxt_rdata = {2'h0, port_c_data_ff};
      `PPOC_OFS_PORTC_PUE: nxt_rdata = {2'h0, port_c_pue_ff};
      `PPOC_OFS_STATUS:    nxt_rdata = {4'h0, clock_pin_busy, clock_output_active,
                                        single_wire_debug_on, reset_pin_disable};
      default:             nxt_rdata = 8'h00;
    endcase
  end

  // read data valid only the cycle after the strobe
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // break-before-make per port
  ppoc_bbm #(.WIDTH(8)) u_bbm_a (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .bbm_en  (port_a_bbm_enable),
    .dir_req (dir_a_ff),
    .dir_out (dir_a_eff)
  );
  ppoc_bbm #(.WIDTH(4)) u_bbm_b (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .bbm_en  (port_b_bbm_enable),
    .dir_req (port_b_dir_req | dir_b_ff),
    .dir_out (port_b_oe)
  );
  ppoc_bbm #(.WIDTH(6)) u_bbm_c (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .bbm_en  (port_c_bbm_enable),
    .dir_req (dir_c_ff),
    .dir_out (dir_c_eff)
  );

  // port A has no overrides here
  assign port_a_out    = port_a_output_data_ff;
  assign port_a_oe     = dir_a_eff;
  assign port_a_pullup = port_a_pullup_enable_ff & ~dir_a_eff;

  // (RULE8) fuse programmed reads 0
  assign reset_pin_disable = ~reset_fuse;
  // (RULE9) debug needs fuse and unlocked part
  assign single_wire_debug_on = ~debug_fuse & (&lock_bits);
  // (RULE13) clock out also during reset
  assign clock_output_active = ~clock_out_fuse | ~rst_n;
  // (RULE2) clock pin busy unless calibrated osc
  assign clock_pin_busy = external_clock_selected | crystal_selected;

  // (RULE4) pin-change gating per source
  assign src14_on = pin_change_src[14] & pin_change_group2_enable;
  assign src15_on = pin_change_src[15] & pin_change_group2_enable;
  assign src16_on = pin_change_src[16] & pin_change_group2_enable;
  assign src17_on = pin_change_src[17] & pin_change_group2_enable;

  // override table for port C
  always @* begin
    pullup_override_enable       = 6'h00;
    pullup_override_value        = 6'h00;
    direction_override_enable    = 6'h00;
    direction_override_value     = 6'h00;
    output_value_override_enable = 6'h00;
    output_value_override_value  = 6'h00;
    input_enable_override_enable = 6'h00;
    input_enable_override_value  = 6'h00;
    // (RULE5) bit 5 clock pin, values 0
    // (RULE3) calibrated osc leaves these off
    pullup_override_enable[5]       = clock_pin_busy;
    direction_override_enable[5]    = clock_pin_busy;
    output_value_override_enable[5] = clock_pin_busy;
    // (RULE6) crystal takes bit 5 input too
    input_enable_override_enable[5] = clock_pin_busy | src17_on;
    // (RULE4) source 17 input enable
    input_enable_override_value[5]  = (external_clock_selected & power_down) |
                                      (external_clock_selected & src17_on) |
                                      (~clock_pin_busy & src17_on);
    // (RULE6) crystal owns bit 4
    pullup_override_enable[4]       = crystal_selected;
    direction_override_enable[4]    = crystal_selected;
    output_value_override_enable[4] = crystal_selected;
    input_enable_override_enable[4] = crystal_selected | src16_on;
    // (RULE7) bit 4 input value
    input_enable_override_value[4]  = crystal_selected & src16_on;
    // (RULE8) reset or debug takes bit 3
    pullup_override_enable[3]       = reset_pin_disable | single_wire_debug_on;
    pullup_override_value[3]        = 1'b1;
    direction_override_enable[3]    = reset_pin_disable | single_wire_debug_on;
    output_value_override_enable[3] = reset_pin_disable | single_wire_debug_on;
    // (RULE10) open-drain debug line
    direction_override_value[3]     = single_wire_debug_on & debug_transmit;
    output_value_override_value[3]  = 1'b0;
    input_enable_override_enable[3] = reset_pin_disable | single_wire_debug_on | src15_on;
    // (RULE11) bit 3 input value
    input_enable_override_value[3]  = single_wire_debug_on | (reset_pin_disable & src15_on);
    // (RULE12) clock output on bit 2
    pullup_override_enable[2]       = clock_output_active;
    direction_override_enable[2]    = clock_output_active;
    direction_override_value[2]     = 1'b1;
    output_value_override_enable[2] = clock_output_active;
    output_value_override_value[2]  = clock_output_active & ref_clk;
    // (RULE14) bit 2 input enable
    input_enable_override_enable[2] = external_interrupt_zero | src14_on;
    input_enable_override_value[2]  = external_interrupt_zero | src14_on;
    // (RULE15) open-drain serial clock
    pullup_override_enable[1]       = two_wire_mode;
    direction_override_enable[1]    = two_wire_mode;
    direction_override_value[1]     = (serial_clock_hold | port_c_data_ff[1]) & dir_c_ff[1];
    output_value_override_enable[1] = two_wire_mode & dir_c_ff[1];
  end

  // (RULE1) overrides replace register values
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_pc
      wire dir_n;
      assign dir_n = ovr(direction_override_enable[gi], direction_override_value[gi],
                         dir_c_eff[gi]);
      assign port_c_oe[gi] = dir_n;
      assign port_c_out[gi] = ovr(output_value_override_enable[gi],
                                  output_value_override_value[gi], port_c_data_ff[gi]);
      assign port_c_pullup[gi] = ovr(pullup_override_enable[gi], pullup_override_value[gi],
                                     port_c_pue_ff[gi] & ~dir_n);
      assign port_c_in_en[gi] = ovr(input_enable_override_enable[gi],
                                    input_enable_override_value[gi], 1'b1);
    end
  endgenerate
endmodule
`default_nettype wire

// ---- bench/ppoc_far.sv ----
`timescale 1ns/1ps
`default_nettype none
// far side of the port: clock choice, fuse levels, peripheral levels
module ppoc_far (
  // setting chosen by the bench
  input  wire logic [16:0] cfg,
  // clock source, one at a time as on a real part
  output logic             ext_clk,
  output logic             xtal,
  // fuses, 0 means programmed
  output logic             rst_fuse,
  output logic             dbg_fuse,
  output logic [1:0]       locks,
  output logic             ck_fuse,
  // pd, hold, two-wire, group, src17..14, external_interrupt_zero, transmit
  output logic [9:0]       lvl
);
  // code 0 and 3 both mean the calibrated oscillator
  assign ext_clk = cfg[1:0] == 2'h1;
  assign xtal = cfg[1:0] == 2'h2;
  assign {ck_fuse, locks, dbg_fuse, rst_fuse} = cfg[6:2];
  assign lvl = cfg[16:7];
endmodule
`default_nettype wire

// ---- bench/ppoc_top_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppoc_top_props #(
  parameter LOCK_W = 2
) (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              rst_n,
  // register port
  input wire logic [5:0]        reg_addr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  // clock choice, fuses, sources
  input wire logic              external_clock_selected,
  input wire logic              crystal_selected,
  input wire logic              reset_fuse,
  input wire logic              debug_fuse,
  input wire logic [LOCK_W-1:0] lock_bits,
  input wire logic              clock_out_fuse,
  input wire logic              debug_transmit,
  input wire logic              external_interrupt_zero,
  input wire logic [17:14]      pin_change_src,
  input wire logic              pin_change_group2_enable,
  // port C and status
  input wire logic [5:0]        port_c_out,
  input wire logic [5:0]        port_c_oe,
  input wire logic [5:0]        port_c_pullup,
  input wire logic [5:0]        port_c_in_en,
  input wire logic              reset_pin_disable,
  input wire logic              single_wire_debug_on,
  input wire logic              clock_output_active
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // read of the control register, answer one cycle on
  sequence s_ctl_rd;
    reg_rd && reg_addr == 6'h13;
  endsequence
  chk_ctl_reserved: assert property (s_ctl_rd |=> reg_rdata[7:3] == 5'h00)
    else $error("control reserved bits not zero");
  chk_reset_disable: assert property (reset_pin_disable == !reset_fuse)
    else $error("reset disable wrong");
  chk_debug_on: assert property (single_wire_debug_on == (!debug_fuse && &lock_bits))
    else $error("debug enable wrong");
  // transmit held steady so a one-cycle turn-around cannot mislead
  chk_bit3_drive: assert property ((reset_pin_disable || single_wire_debug_on)
    && $stable(debug_transmit) |-> port_c_oe[3] == (single_wire_debug_on && debug_transmit)
    && port_c_out[3] == 1'b0) else $error("bit 3 override wrong");
  chk_bit3_pull: assert property (reset_pin_disable && !single_wire_debug_on
    |-> port_c_pullup[3]) else $error("bit 3 pull-up off");
  // reset term kept: the release edge still samples the reset-time level
  chk_clk_fuse: assert property (clock_output_active == (!clock_out_fuse || !rst_n))
    else $error("clock output enable wrong");
  chk_clk_pin: assert property (clock_output_active[*2]
    |-> port_c_oe[2] && port_c_out[2] == ref_clk) else $error("clock pin not driven");
  chk_xtal_pins: assert property (crystal_selected |-> port_c_oe[5:4] == 2'h0
    && port_c_in_en[4] == (pin_change_src[16] && pin_change_group2_enable))
    else $error("crystal pins wrong");
  chk_ext_clk: assert property (external_clock_selected && !crystal_selected
    |-> port_c_oe[5] == 1'b0 && port_c_out[5] == 1'b0 && port_c_pullup[5] == 1'b0)
    else $error("external clock pin wrong");
  chk_external_interrupt_zero_input: assert property (external_interrupt_zero
    || pin_change_src[14] && pin_change_group2_enable |-> port_c_in_en[2])
    else $error("bit 2 input off");
  chk_src17_input: assert property (!external_clock_selected && !crystal_selected
    && pin_change_src[17] && pin_change_group2_enable |-> port_c_in_en[5])
    else $error("bit 5 input off");
endmodule
`default_nettype wire

// ---- bench/test_port_pin_override_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_port_pin_override_control;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  reg_addr = 6'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [16:0] cfg = 17'h00040;
  logic [7:0]  mdl [0:63];
  logic [5:0]  a;
  int          err_total = 0;
  int          cmp_count = 0;
  wire  [7:0]  reg_rdata, pa_out, pa_oe, pa_pu;
  wire  [3:0]  pb_oe;
  wire  [5:0]  pc_out, pc_oe, pc_pu, pc_in;
  wire         ext, xt, rf, df, cf, rpd, dbg, cko;
  wire  [1:0]  locks;
  wire  [9:0]  lvl;
  ppoc_far ppoc_far_i (.cfg(cfg), .ext_clk(ext), .xtal(xt), .rst_fuse(rf), .dbg_fuse(df),
    .locks(locks), .ck_fuse(cf), .lvl(lvl));
  ppoc_top ppoc_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .external_clock_selected(ext), .crystal_selected(xt), .reset_fuse(rf), .debug_fuse(df),
    .lock_bits(locks), .clock_out_fuse(cf), .power_down(lvl[9]), .debug_transmit(lvl[0]),
    .external_interrupt_zero(lvl[1]), .pin_change_src(lvl[5:2]),
    .pin_change_group2_enable(lvl[6]), .two_wire_mode(lvl[7]), .serial_clock_hold(lvl[8]),
    .port_b_dir_req(4'h0), .port_a_out(pa_out), .port_a_oe(pa_oe), .port_a_pullup(pa_pu),
    .port_b_oe(pb_oe), .port_c_out(pc_out), .port_c_oe(pc_oe), .port_c_pullup(pc_pu),
    .port_c_in_en(pc_in), .reset_pin_disable(rpd), .single_wire_debug_on(dbg),
    .clock_output_active(cko));
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // writable bits per address; unmapped places hold nothing
  function automatic logic [7:0] msk(input logic [5:0] ad);
    case (ad)
      6'h11, 6'h12, 6'h14: msk = 8'hff;
      6'h13: msk = 8'h07;
      6'h15: msk = 8'h0f;
      6'h16, 6'h17, 6'h18: msk = 8'h3f;
      default: msk = 8'h00;
    endcase
  endfunction
  task automatic wr(input logic [5:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    mdl[ad] = d & msk(ad);
    #1;
  endtask
  task automatic rdc(input logic [5:0] ad);
    @(posedge ref_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    cmp("reg_rdata", mdl[ad], reg_rdata);
  endtask
  function automatic logic oe0(input int p);
    oe0 = p == 0 ? pa_oe[0] : p == 1 ? pb_oe[0] : pc_oe[0];
  endfunction
  // expected pin controls worked out from the current far-side setting
  task automatic ovr_check();
    logic ex, x, dg, o3, s15, s16, s17;
    logic [5:0] e;
    ex = cfg[1:0] == 2'h1;
    x = cfg[1:0] == 2'h2;
    dg = !cfg[3] && &cfg[5:4];
    o3 = !cfg[2] || dg;
    s15 = cfg[10] && cfg[13];
    s16 = cfg[11] && cfg[13];
    s17 = cfg[12] && cfg[13];
    e = {!(ex || x), !x, o3 && dg && cfg[7], !cfg[6], cfg[14] ? cfg[15] : 1'b1, 1'b0};
    cmp("port_c_oe", {2'h0, e}, {2'h0, pc_oe});
    e[3] = (ex || x || s17) ? (ex && cfg[16] || ex && s17 || !ex && !x && s17) : 1'b1;
    e[2] = (x || s16) ? (x && s16) : 1'b1;
    e[1] = (o3 || s15) ? (dg || !cfg[2] && s15) : 1'b1;
    cmp("port_c_in_en", {2'h0, e[3:1], 3'h7}, {2'h0, pc_in});
    cmp("status", {5'h00, !cfg[2], dg, !cfg[6]}, {5'h00, rpd, dbg, cko});
    // data 0x39, checked just after a rising edge so the clock pin shows 1
    cmp("port_c_out", {2'h0, !(ex || x), !x, !o3, !cfg[6], 2'h1}, {2'h0, pc_out});
    cmp("port_c_pullup", {4'h0, 1'b1, cfg[6], 2'h1}, {2'h0, pc_pu});
    mdl[6'h19] = {4'h0, ex || x, !cfg[6], dg, !cfg[2]};
    rdc(6'h19);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    test_done();
  end
  initial begin
    void'($urandom(97413));
    for (int i = 0; i < 64; i++) mdl[i] = 8'h00;
    repeat (9) @(posedge ref_clk);
    #1;
    cmp("reset clock pin", 8'h03, {6'h00, pc_oe[2], cko});
    @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) rdc(6'h11 + 6'(i));
    // each port alone, with and without the tri-state gap
    for (int p = 0; p < 3; p++) begin
      for (int b = 0; b < 2; b++) begin
        wr(6'h13, 8'(b << p));
        wr(6'h14 + 6'(p), 8'h00);
        wr(6'h14 + 6'(p), 8'h01);
        cmp("oe first cycle", 8'(b == 0), 8'(oe0(p)));
        @(posedge ref_clk);
        #1;
        cmp("oe second cycle", 8'h01, 8'(oe0(p)));
      end
    end
    for (int n = 0; n < 60; n++) begin
      a = (n % 10 == 9) ? 6'h20 : 6'h11 + 6'($urandom % 8);
      if ($urandom % 2) wr(a, 8'($urandom));
      else rdc(a);
      cmp("port_a_out", mdl[6'h11], pa_out);
    end
    // one more edge so any tri-state gap is over
    @(posedge ref_clk);
    #1;
    cmp("port_a_oe", mdl[6'h14], pa_oe);
    cmp("port_a_pullup", mdl[6'h12] & ~mdl[6'h14], pa_pu);
    cmp("port_b_oe", mdl[6'h15], {4'h0, pb_oe});
    wr(6'h13, 8'h00);
    wr(6'h16, 8'h32);
    wr(6'h17, 8'h39);
    wr(6'h18, 8'h3f);
    for (int n = 0; n < 48; n++) begin
      @(posedge ref_clk);
      cfg <= 17'($urandom);
      @(posedge ref_clk);
      #1;
      ovr_check();
    end
    test_done();
  end
endmodule
bind ppoc_top ppoc_top_props #(.LOCK_W(LOCK_W)) ppoc_top_props_i (.ref_clk(ref_clk),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .external_clock_selected(external_clock_selected), .crystal_selected(crystal_selected),
  .reset_fuse(reset_fuse), .debug_fuse(debug_fuse), .lock_bits(lock_bits),
  .clock_out_fuse(clock_out_fuse), .debug_transmit(debug_transmit),
  .external_interrupt_zero(external_interrupt_zero), .pin_change_src(pin_change_src),
  .pin_change_group2_enable(pin_change_group2_enable), .port_c_out(port_c_out),
  .port_c_oe(port_c_oe), .port_c_pullup(port_c_pullup), .port_c_in_en(port_c_in_en),
  .reset_pin_disable(reset_pin_disable), .single_wire_debug_on(single_wire_debug_on),
  .clock_output_active(clock_output_active));
`default_nettype wire
